/* File: core/stepper_core_pkg.sv */
/*
 Constants, register map and types shared by the stepper control core.
 Assumes a 20 MHz core clock and APB register access, one 8-bit
 register per aligned 32-bit word.
*/
`default_nettype none
package stepper_core_pkg;
   // ****************************************
   // Register indices (byte address = 4*idx)
   // ****************************************
   localparam int         NUM_REGS  = 10;
   localparam logic [3:0] IDX_MODE  = 4'h0;
   localparam logic [3:0] IDX_WDT   = 4'h1;
   localparam logic [3:0] IDX_DIR   = 4'h2;
   localparam logic [3:0] IDX_MASK  = 4'h3;
   localparam logic [3:0] IDX_EDGE  = 4'h4;
   localparam logic [3:0] IDX_FLAG  = 4'h5;
   localparam logic [3:0] IDX_INPUT = 4'h6;
   localparam logic [3:0] IDX_MOTOR = 4'h7;
   localparam logic [3:0] IDX_PULSE = 4'h8;
   localparam logic [3:0] IDX_OUT   = 4'h9;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int MODE_IRQ_OFF_BIT = 5;
   localparam int WDT_EN_BIT       = 0;
   localparam int WDT_FLAG_BIT     = 3;
   localparam int MC_RUN_BIT       = 7;
   localparam int MC_DIR_BIT       = 2;
   localparam int EDGE_FALL_LSB    = 4;
   localparam logic [1:0] FMT_WAVE = 2'h0;
   localparam logic [1:0] FMT_TWO  = 2'h1;
   // ****************************************
   // Reset values, indexed by register
   // ****************************************
   localparam logic [7:0] REG_RESET [NUM_REGS] = '{
      8'h00, 8'h00, 8'h0f, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // ****************************************
   // Timing and serial bus codes
   // ****************************************
   localparam int READY_TIME_US = 1000;
   localparam int CLK_FREQ_MHZ  = 20;
   localparam int READY_CYCLES  = READY_TIME_US * CLK_FREQ_MHZ;
   localparam int PULSE_SHIFT   = 8;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0] RESET_CODE    = 8'h06;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       en;
      logic [3:0] idx;
      logic [7:0] data;
   } reg_wr_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_RX   = 6'b000100,
      ST_ACK  = 6'b001000,
      ST_TX   = 6'b010000,
      ST_SKIP = 6'b100000
   } bus_state_t;
endpackage
`default_nettype wire

/* File: core/stepper_phase_reset_irq_core.sv */
/*
 Stepper control core: reset handling, serial bus slave with general
 call software reset, pin and watchdog interrupts, coil phase generator.
 Assumes APB on clk, open-drain pins resolved outside, and a watchdog
 timeout pulse from logic on the same clock.
*/
`default_nettype none
module stepper_phase_reset_irq_core
   import stepper_core_pkg::*;
#(
   parameter int         READY_CYC = READY_CYCLES,
   parameter logic [6:0] DEV_ADDR  = 7'h2a
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        rst_pin_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic [3:0]  general_pins_in,
   output logic      [3:0]  general_pins_out,
   output logic      [3:0]  general_pins_oe_n,
   output logic             int_out,
   output logic             int_oe_n,
   input  wire logic        wdt_expire,
   output logic      [3:0]  coil_out,
   output logic             device_ready
);
   localparam int NSYNC = 7;
   localparam int RW    = $clog2(READY_CYC + 1);

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] lvl;
   logic             hard_rst;
   logic             soft_rst;
   logic             core_rst;
   logic [RW-1:0]    ready_cnt;
   logic [7:0]       regs [NUM_REGS];
   logic             wdt_flag;
   logic [3:0]       pin_flag;
   logic [3:0]       in_latch;
   logic [3:0]       pin_in;
   logic [3:0]       pin_dir;
   logic [3:0]       pin_rise;
   logic [3:0]       pin_fall;
   logic [3:0]       pin_hit;
   logic [3:0]       flag_clr;
   reg_wr_t          apb_wr;
   reg_wr_t          i2c_wr;
   reg_wr_t          wr_sel;
   logic             apb_hit;
   logic [7:0]       apb_idx;
   logic             scl_d;
   logic             sda_d;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_c;
   logic             stop_c;
   bus_state_t       state;
   logic [3:0]       bcnt;
   logic [1:0]       byte_no;
   logic [7:0]       shreg;
   logic [7:0]       ptr;
   logic [7:0]       i2c_rd;
   logic             rw;
   logic             gc;
   logic             gc_arm;
   logic             sda_drv;
   logic             ack_ok;
   logic [1:0]       fmt;
   logic             ccw;
   logic             run;
   logic             run_d;
   logic             started;
   logic [2:0]       phase;
   logic [2:0]       step;
   logic [2:0]       phase_fix;
   logic [15:0]      timer;
   logic [15:0]      timer_end;

   // ****************************************
   // Input synchronisers
   // ****************************************
   assign raw_in = {general_pins_in, rst_pin_n, sda_in, scl_in};

   for (genvar g = 0; g < NSYNC; g++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic s_lvl;
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            s_lvl <= 1'b1;
         end else begin
            s1 <= raw_in[g];
            s2 <= s1;
            s3 <= s2;
            // Level moves only when the later stages agree
            if (s2 == s3) begin
               s_lvl <= s3;
            end
         end
      end
      assign lvl[g] = s_lvl;
   end

   // ****************************************
   // Reset and ready
   // ****************************************
   assign hard_rst = sys_rst | ~lvl[2];
   assign core_rst = hard_rst | soft_rst;

   always_ff @(posedge clk) begin
      if (hard_rst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= stop_c & gc_arm & ~soft_rst;
      end
   end

   always_ff @(posedge clk) begin
      if (core_rst) begin
         ready_cnt <= RW'(READY_CYC);
      end else if (ready_cnt != '0) begin
         ready_cnt <= ready_cnt - 1'b1;
      end
   end

   assign device_ready = (ready_cnt == '0);

   // ****************************************
   // Register file
   // ****************************************
   // APB wins a same-cycle clash; the serial write is then dropped
   assign wr_sel = apb_wr.en ? apb_wr : i2c_wr;

   always_ff @(posedge clk) begin
      if (core_rst) begin
         regs <= REG_RESET;
      end else if (wr_sel.en && wr_sel.idx < 4'(NUM_REGS)) begin
         regs[wr_sel.idx] <= wr_sel.data;
      end
   end

   function automatic logic [7:0] reg_val(input logic [7:0] i);
      logic [7:0] v;
      v = 8'h00;
      if (i == {4'h0, IDX_WDT}) begin
         v = regs[IDX_WDT];
         v[WDT_FLAG_BIT] = wdt_flag;
      end else if (i == {4'h0, IDX_FLAG}) begin
         v = {4'h0, pin_flag};
      end else if (i == {4'h0, IDX_INPUT}) begin
         v = {4'h0, in_latch};
      end else if (i < 8'(NUM_REGS)) begin
         v = regs[i[3:0]];
      end
      return v;
   endfunction

   // ****************************************
   // APB slave
   // ****************************************
   assign apb_idx = {4'h0, paddr[5:2]};
   assign apb_hit = (paddr[1:0] == 2'b00) && (paddr[31:6] == 26'h0) &&
                    (paddr[5:2] < 4'(NUM_REGS));
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~apb_hit;
   assign apb_wr  = '{en:   psel & penable & pwrite & apb_hit,
                      idx:  paddr[5:2],
                      data: pwdata[7:0]};

   always_ff @(posedge clk) begin
      if (core_rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= apb_hit ? {24'h0, reg_val(apb_idx)} : 32'h0;
      end
   end

   // ****************************************
   // Watchdog and pin interrupts
   // ****************************************
   always_ff @(posedge clk) begin
      if (core_rst) begin
         wdt_flag <= 1'b0;
      end else if (wdt_expire && regs[IDX_WDT][WDT_EN_BIT]) begin
         wdt_flag <= 1'b1;
      end else if (wr_sel.en && wr_sel.idx == IDX_WDT &&
                   wr_sel.data[WDT_FLAG_BIT]) begin
         wdt_flag <= 1'b0;
      end
   end

   assign pin_in   = lvl[6:3];
   assign pin_dir  = regs[IDX_DIR][3:0];
   // Latch is frozen while a pin drives, so a switch back can fire
   assign pin_rise = pin_dir & pin_in & ~in_latch;
   assign pin_fall = pin_dir & ~pin_in & in_latch;
   assign pin_hit  = regs[IDX_MASK][3:0] &
                     ((pin_rise & regs[IDX_EDGE][3:0]) |
                      (pin_fall &
                       regs[IDX_EDGE][EDGE_FALL_LSB +: 4]));
   assign flag_clr = (wr_sel.en && wr_sel.idx == IDX_FLAG) ?
                     wr_sel.data[3:0] : 4'h0;

   always_ff @(posedge clk) begin
      if (core_rst) begin
         in_latch <= 4'hf;
      end else begin
         in_latch <= (pin_dir & pin_in) | (~pin_dir & in_latch);
      end
   end

   always_ff @(posedge clk) begin
      if (core_rst) begin
         pin_flag <= 4'h0;
      end else begin
         // Set wins over a clear in the same cycle
         pin_flag <= (pin_flag & ~flag_clr) | pin_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (core_rst) begin
         int_oe_n <= 1'b1;
      end else begin
         int_oe_n <= ~((wdt_flag | (|pin_flag)) &
                       ~regs[IDX_MODE][MODE_IRQ_OFF_BIT]);
      end
   end

   assign int_out           = 1'b0;
   assign general_pins_out  = regs[IDX_OUT][3:0];
   assign general_pins_oe_n = pin_dir;

   // ****************************************
   // Serial bus slave
   // ****************************************
   assign scl_rise = lvl[0] & ~scl_d;
   assign scl_fall = ~lvl[0] & scl_d;
   assign start_c  = scl_d & lvl[0] & sda_d & ~lvl[1];
   assign stop_c   = scl_d & lvl[0] & ~sda_d & lvl[1];
   assign i2c_rd   = reg_val(ptr);
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~sda_drv;

   always_ff @(posedge clk) begin
      if (core_rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= lvl[0];
         sda_d <= lvl[1];
      end
   end

   always_comb begin
      ack_ok = 1'b0;
      if (state == ST_ADDR) begin
         ack_ok = (shreg[7:1] == DEV_ADDR) ||
                  (shreg[7:1] == GEN_CALL_ADDR && !shreg[0]);
      end else if (gc) begin
         ack_ok = (byte_no == 2'd1) && (shreg == RESET_CODE);
      end else begin
         ack_ok = (byte_no != 2'd3);
      end
   end

   always_ff @(posedge clk) begin
      if (core_rst) begin
         state   <= ST_IDLE;
         bcnt    <= 4'h0;
         byte_no <= 2'd0;
         shreg   <= 8'h00;
         ptr     <= 8'h00;
         rw      <= 1'b0;
         gc      <= 1'b0;
         gc_arm  <= 1'b0;
         sda_drv <= 1'b0;
         i2c_wr  <= '0;
      end else begin
         i2c_wr.en <= 1'b0;
         if (start_c && device_ready) begin
            state   <= ST_ADDR;
            bcnt    <= 4'h0;
            byte_no <= 2'd0;
            gc      <= 1'b0;
            gc_arm  <= 1'b0;
            sda_drv <= 1'b0;
         end else if (stop_c) begin
            state   <= ST_IDLE;
            sda_drv <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], lvl[1]};
                     bcnt  <= bcnt + 4'd1;
                  end else if (scl_fall && bcnt == 4'd8) begin
                     bcnt <= 4'h0;
                     if (byte_no != 2'd3) begin
                        byte_no <= byte_no + 2'd1;
                     end
                     if (state == ST_ADDR) begin
                        rw <= shreg[0];
                        gc <= (shreg[7:1] == GEN_CALL_ADDR);
                     end else if (gc) begin
                        gc_arm <= ack_ok;
                     end else if (byte_no == 2'd1) begin
                        ptr <= shreg;
                     end else if (byte_no == 2'd2) begin
                        i2c_wr <= '{en:   (ptr[7:4] == 4'h0),
                                    idx:  ptr[3:0],
                                    data: shreg};
                     end
                     if (ack_ok) begin
                        sda_drv <= 1'b1;
                        state   <= ST_ACK;
                     end else begin
                        state <= ST_SKIP;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bcnt <= 4'h0;
                     if (rw && !gc) begin
                        shreg   <= i2c_rd;
                        sda_drv <= ~i2c_rd[7];
                        state   <= ST_TX;
                     end else begin
                        sda_drv <= 1'b0;
                        state   <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bcnt <= bcnt + 4'd1;
                  end else if (scl_fall) begin
                     if (bcnt == 4'd8) begin
                        // Single byte read: ignore the master's answer
                        sda_drv <= 1'b0;
                        state   <= ST_SKIP;
                     end else begin
                        shreg   <= {shreg[6:0], 1'b0};
                        sda_drv <= ~shreg[6];
                     end
                  end
               end
               ST_IDLE, ST_SKIP: begin
                  sda_drv <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Phase sequence generator
   // ****************************************
   assign fmt       = regs[IDX_MOTOR][1:0];
   assign ccw       = regs[IDX_MOTOR][MC_DIR_BIT];
   assign run       = regs[IDX_MOTOR][MC_RUN_BIT];
   assign timer_end = {regs[IDX_PULSE], {PULSE_SHIFT{1'b1}}};
   assign step      = (fmt == FMT_WAVE || fmt == FMT_TWO) ? 3'd2 : 3'd1;

   always_comb begin
      case (fmt)
         FMT_WAVE: phase_fix = {phase[2:1], 1'b0};
         FMT_TWO:  phase_fix = {phase[2:1], 1'b1};
         default:  phase_fix = phase;
      endcase
   end

   // Bit 0 is winding D on the zero output, bit 3 is winding A
   function automatic logic [3:0] coil_map(input logic [2:0] p);
      logic [3:0] c;
      c = 4'h0;
      case (p)
         3'd0:    c = 4'h1;
         3'd1:    c = 4'h3;
         3'd2:    c = 4'h2;
         3'd3:    c = 4'h6;
         3'd4:    c = 4'h4;
         3'd5:    c = 4'hc;
         3'd6:    c = 4'h8;
         default: c = 4'h9;
      endcase
      return c;
   endfunction

   always_ff @(posedge clk) begin
      if (core_rst) begin
         run_d   <= 1'b0;
         started <= 1'b0;
         phase   <= 3'd0;
         timer   <= 16'h0;
         coil_out <= 4'h0;
      end else begin
         run_d <= run;
         if (run && !run_d) begin
            timer <= 16'h0;
            if (!started) begin
               started <= 1'b1;
               phase   <= ccw ? 3'd6 : 3'd0;
            end
         end else if (run) begin
            if (timer == timer_end) begin
               timer <= 16'h0;
               phase <= ccw ? phase_fix - step :
                              phase_fix + step;
            end else begin
               timer <= timer + 16'd1;
            end
         end
         coil_out <= (run && run_d) ? coil_map(phase_fix) : 4'h0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/stepper_core_monitor.sv */
/* Port checker for the stepper core.
   Assumes binding into the core top, all ports on clk. */
`default_nettype none
module stepper_core_monitor #(
   parameter int READY_CYC = 50
)(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       rst_pin_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       int_out,
   input wire logic       int_oe_n,
   input wire logic [3:0] coil_out,
   input wire logic       device_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Helper counters
   // ****************
   // Slack covers the pin synchroniser
   localparam int LO = READY_CYC - 2;
   localparam int HI = READY_CYC + 8;
   int         lowcnt;
   int         stab;
   logic [3:0] prev;
   logic       step;
   assign step = coil_out != prev && prev != 4'h0 && coil_out != 4'h0;
   always_ff @(posedge clk) begin
      if (sys_rst || !rst_pin_n || device_ready)
         lowcnt <= 0;
      else
         lowcnt <= lowcnt + 1;
   end
   always_ff @(posedge clk) begin
      prev <= coil_out;
      if (coil_out != prev)
         stab <= 0;
      else if (stab < 5000)
         stab <= stab + 1;
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   rst_dflt_a: assert property ($past(sys_rst) |->
      coil_out == 4'h0 && int_oe_n && sda_oe_n && !device_ready)
      else $error("outputs not at reset values");
   ready_time_a: assert property ($rose(device_ready) |->
      lowcnt >= LO && lowcnt <= HI)
      else $error("ready delay out of range");
   idle_bus_a: assert property (!device_ready |-> sda_oe_n)
      else $error("data pulled before ready");
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase not ready");
   open_drain_a: assert property (!sda_out && !int_out)
      else $error("open drain level not low");
   coil_legal_a: assert property (coil_out inside
      {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h9})
      else $error("illegal coil pattern");
   coil_step_a: assert property (step |-> (coil_out & prev) != 0 ||
      coil_out == {prev[2:0], prev[3]} || coil_out == {prev[0], prev[3:1]})
      else $error("coil step not adjacent");
   coil_hold_a: assert property (step |-> stab >= 255)
      else $error("coil step too early");
   cover property ($rose(device_ready));
   cover property ($fell(int_oe_n));
   cover property ($fell(sda_oe_n));
   cover property (step && coil_out == 4'h9);
endmodule
bind stepper_phase_reset_irq_core stepper_core_monitor #(
   .READY_CYC(READY_CYC)) mon (.clk, .sys_rst, .rst_pin_n, .psel,
   .penable, .pready, .sda_out, .sda_oe_n, .int_out, .int_oe_n,
   .coil_out, .device_ready);
`default_nettype wire

/* File: testbench/i2c_host_model.sv */
/* Serial bus host: drives the clock, pulls data low.
   Assumes a pulled-up data wire resolved by the bench. */
`default_nettype none
module i2c_host_model (
   input  wire logic clk,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Bus phases
   // ****************
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic q(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic start();
      sda_low <= 1'b0;
      q(3);
      scl <= 1'b1;
      q(3);
      sda_low <= 1'b1;
      q(2);
      scl <= 1'b0;
      q(2);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      q(4);
      scl <= 1'b1;
      q(3);
      sda_low <= 1'b0;
      q(8);
   endtask
   // Long low phase: device moves data ~5 clk after fall
   task automatic bitx(input logic b, output logic r);
      sda_low <= !b;
      q(3);
      scl <= 1'b1;
      q(2);
      r = sda;
      q(1);
      scl <= 1'b0;
      q(2);
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rd(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, d[i]);
      bitx(1'b1, r);
   endtask
endmodule
`default_nettype wire

/* File: testbench/stepper_phase_reset_irq_core_test.sv */
/* Self-checking bench for the stepper core.
   Assumes the host model and the bound port checker. */
`default_nettype none
module stepper_phase_reset_irq_core_test;
   import stepper_core_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         RC = 50;
   localparam logic [6:0] DA = 7'h2a;
   localparam logic [3:0] HS [8] = '{4'h1, 4'h3, 4'h2, 4'h6,
                                     4'h4, 4'hc, 4'h8, 4'h9};
   logic        clk = 1'b0;
   logic        sys_rst, rst_pin_n, psel, penable, pwrite, wdt_expire;
   logic [31:0] paddr, pwdata, prdata;
   logic        pready, pslverr, scl, sda_low, sda_out, sda_oe_n;
   logic [3:0]  pin_drv, gp_out, gp_oe_n, coil_out;
   logic        int_out, int_oe_n, device_ready;
   wire  logic  sda = !(sda_low || !sda_oe_n);
   wire  logic [3:0] pins = (gp_oe_n & pin_drv) | (~gp_oe_n & gp_out);
   int          mismatches = 0;
   int          check_count = 0;
   always #25 clk = ~clk;
   stepper_phase_reset_irq_core #(.READY_CYC(RC), .DEV_ADDR(DA)) dut (
      .clk, .sys_rst, .rst_pin_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe_n, .general_pins_in(pins),
      .general_pins_out(gp_out), .general_pins_oe_n(gp_oe_n), .int_out,
      .int_oe_n, .wdt_expire, .coil_out, .device_ready);
   i2c_host_model host (.clk, .sda, .scl, .sda_low);
   // ****************
   // Shared tasks
   // ****************
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (k == 20)
         chk("pready wait", 1, 0);
      if (k == 20)
         results();
   endtask
   task automatic wreg(input logic [3:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, {26'h0, i, 2'b00}, d, r, e);
   endtask
   task automatic rchk(input logic [3:0] i, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, {26'h0, i, 2'b00}, 8'h00, r, e);
      chk("register", {24'h0, x}, r);
   endtask
   task automatic wait_ready();
      int k;
      for (k = 0; k < RC + 20 && device_ready !== 1'b1; k++)
         @(posedge clk);
      chk("ready in time", 1, k < RC + 20);
      if (k == RC + 20)
         results();
   endtask
   task automatic sw(input logic [7:0] d, input logic x);
      logic a;
      host.wr(d, a);
      chk("serial ack", x, a);
   endtask
   task automatic wdt_pulse();
      wdt_expire <= 1'b1;
      tick(1);
      wdt_expire <= 1'b0;
      tick(3);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < NUM_REGS; i++)
         rchk(4'(i), REG_RESET[i]);
      apb(1'b0, 32'h28, 8'h00, r, e);
      chk("unmapped", 1, e);
      chk("unmapped rd", 0, r);
      wreg(IDX_MASK, 8'h05);
      rst_pin_n <= 1'b0;
      tick(10);
      chk("ready held", 0, device_ready);
      rst_pin_n <= 1'b1;
      wait_ready();
      rchk(IDX_MASK, 8'h00);
      run(8'h04, 4'h8, 2, r[3:0]);
      $display("test reset done");
   endtask
   task automatic t_serial();
      logic [7:0] d;
      host.start();
      sw({DA, 1'b0}, 1);
      sw({4'h0, IDX_PULSE}, 1);
      sw(8'h5a, 1);
      host.stop();
      rchk(IDX_PULSE, 8'h5a);
      host.start();
      sw({DA, 1'b0}, 1);
      sw({4'h0, IDX_PULSE}, 1);
      host.start();
      sw({DA, 1'b1}, 1);
      host.rd(d);
      host.stop();
      chk("serial read", 8'h5a, d);
      $display("test serial done");
   endtask
   task automatic t_bus_reset_command();
      wreg(IDX_MASK, 8'h03);
      host.start();
      sw({GEN_CALL_ADDR, 1'b1}, 0);
      host.stop();
      host.start();
      sw({GEN_CALL_ADDR, 1'b0}, 1);
      sw(8'h05, 0);
      host.stop();
      host.start();
      sw({GEN_CALL_ADDR, 1'b0}, 1);
      sw(RESET_CODE, 1);
      sw(RESET_CODE, 0);
      host.start();
      sw({GEN_CALL_ADDR, 1'b0}, 1);
      sw(RESET_CODE, 1);
      host.start();
      host.stop();
      chk("no reset", 1, device_ready);
      rchk(IDX_MASK, 8'h03);
      host.start();
      sw({GEN_CALL_ADDR, 1'b0}, 1);
      sw(RESET_CODE, 1);
      host.stop();
      chk("soft reset", 0, device_ready);
      wait_ready();
      rchk(IDX_MASK, 8'h00);
      $display("test soft reset done");
   endtask
   task automatic t_irq();
      wdt_pulse();
      rchk(IDX_WDT, 8'h00);
      wreg(IDX_WDT, 8'h01);
      wdt_pulse();
      chk("wdt irq", 0, int_oe_n);
      rchk(IDX_WDT, 8'h09);
      wreg(IDX_WDT, 8'h09);
      tick(1);
      chk("irq clear", 1, int_oe_n);
      wreg(IDX_MODE, 8'h20);
      wdt_pulse();
      chk("irq gated", 1, int_oe_n);
      rchk(IDX_WDT, 8'h09);
      wreg(IDX_WDT, 8'h08);
      wreg(IDX_MODE, 8'h00);
      wreg(IDX_DIR, 8'h07);
      wreg(IDX_MASK, 8'h0d);
      wreg(IDX_EDGE, 8'h4b);
      pin_drv <= 4'hf;
      tick(10);
      rchk(IDX_FLAG, 8'h01);
      chk("pin irq", 0, int_oe_n);
      pin_drv <= 4'h0;
      tick(10);
      rchk(IDX_FLAG, 8'h05);
      wreg(IDX_FLAG, 8'h05);
      rchk(IDX_FLAG, 8'h00);
      chk("pin irq off", 1, int_oe_n);
      $display("test irq done");
   endtask
   // First compare skipped when the start state is unknown
   task automatic run(input logic [7:0] mc, input logic [3:0] first,
                      input int n, output logic [3:0] last);
      int         k, i, st;
      logic [3:0] v;
      wreg(IDX_MOTOR, mc | 8'h80);
      st = (mc[1:0] == FMT_WAVE || mc[1:0] == FMT_TWO) ? 2 : 1;
      st = mc[2] ? 8 - st : st;
      v = 4'h0;
      for (int s = 0; s <= n; s++) begin
         for (k = 0; k < 600 && (coil_out === v || coil_out === 0); k++)
            @(posedge clk);
         if (k == 600) begin
            chk("coil wait", 1, 0);
            results();
         end
         if (s == 0 && first !== 4'h0)
            chk("first coil", first, coil_out);
         if (s > 1)
            chk("step time", 256, k);
         i = (i + st) % 8;
         if (s > 1 || (s == 1 && first !== 4'h0))
            chk("next coil", HS[i], coil_out);
         for (int j = 0; j < 8; j++)
            if (HS[j] === coil_out)
               i = j;
         v = coil_out;
      end
      last = v;
      wreg(IDX_MOTOR, mc);
      tick(1);
      chk("coils off", 0, coil_out);
   endtask
   task automatic t_coil();
      logic [3:0] l;
      run(8'h00, 4'h1, 5, l);
      run(8'h00, l, 4, l);
      run({6'h0, FMT_TWO}, 4'h0, 5, l);
      run(8'h06, 4'h0, 9, l);
      run(8'h07, 4'h0, 4, l);
      $display("test coil done");
   endtask
   initial begin
      sys_rst = 1'b1;
      rst_pin_n = 1'b1;
      {psel, penable, pwrite, wdt_expire} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pin_drv = 4'h0;
      tick(20);
      sys_rst <= 1'b0;
      wait_ready();
      t_reset();
      t_serial();
      t_bus_reset_command();
      t_irq();
      t_coil();
      results();
   end
endmodule
`default_nettype wire
